// file: hdl/ltg_traffic.v
/*
 * Traffic generator and checker for a four-segment packet link core,
 * with an APB register block for mode, status and error flags.
 * Assumes the core's user side runs on pclk and its inputs are
 * synchronous to it.
 */
// Function
// - Duplex runs generator and checker with loopback
// - Transmit-only enables generator alone
// - Receive-only enables checker alone
// - Generator leaves idle on reset complete
// - Lock step drives link-lock control values
// - Wait alignment or override, then enable
// - Transmit starts on init done and ready
// - First state sends start, checks packet count
// - Second state sends rest until end
// - Ready low holds, resumes same state
// - Done flag, clear busy, back idle
// - Checker lock sets locked and busy
// - Alignment enables checker, then receive
// - Per-segment data and channel, mty compare
// - Any mismatch sets sticky error
// - All packets in sets receive done
// - Report done and failed from error
// - Restart clears, waits delayed request
`timescale 1ns/1ps
`default_nettype none
`include "ltg_regs.vh"

module ltg_traffic (
	input  wire         pclk,            // System clock
	input  wire         presetn,         // Async reset, active low
	input  wire         psel,            // APB select
	input  wire         penable,         // APB enable
	input  wire         pwrite,          // APB write
	input  wire [11:0]  paddr,           // APB address
	input  wire [31:0]  pwdata,          // APB write data
	output reg  [31:0]  prdata,          // APB read data
	output wire         pready,          // APB ready
	output wire         pslverr,         // APB error
	input  wire         reset_done,      // Core reset complete
	input  wire         stat_rx_aligned, // Core receive aligned
	input  wire         tx_rdyout,       // Core transmit ready
	output reg  [511:0] tx_data,         // Transmit data, 4 segments
	output reg  [3:0]   tx_ena,          // Segment enables
	output reg  [3:0]   tx_sop,          // Start markers
	output reg  [3:0]   tx_eop,          // End markers
	output reg  [15:0]  tx_mty,          // Empty bytes per segment
	output reg  [43:0]  tx_chan,         // Channel per segment
	input  wire [511:0] rx_data,         // Receive data
	input  wire [3:0]   rx_ena,          // Receive enables
	input  wire [3:0]   rx_sop,          // Receive start markers
	input  wire [3:0]   rx_eop,          // Receive end markers
	input  wire [15:0]  rx_mty,          // Receive empty bytes
	input  wire [43:0]  rx_chan,         // Receive channels
	output reg          ctl_tx_enable,   // Core transmit enable
	output reg  [7:0]   ctl_tx_mubits,   // Multi-use bits
	output reg  [11:0]  ctl_lanestat,    // Per-lane diagnostic status
	output reg          ctl_intfstat,    // Interface diagnostic status
	output reg          ctl_rx_enable,   // Checker enable
	output wire         ctl_loopback,    // Serial loopback request
	output wire         ctl_flow_packet, // 1 packet, 0 burst
	output reg          mon_done,        // Checker done
	output reg          mon_failed       // Checker failed
);
	// ==========================================================
	// State codes
	localparam [9:0] G_IDLE = 10'h001, G_LOCK = 10'h002,
		G_WAL = 10'h004, G_EN = 10'h008, G_INIT = 10'h010,
		G_TX0 = 10'h020, G_TX1 = 10'h040, G_HOLD = 10'h080,
		G_DONE = 10'h100, G_RST = 10'h200;
	localparam [8:0] C_IDLE = 9'h001, C_LOCK = 9'h002,
		C_WAL = 9'h004, C_EN = 9'h008, C_INIT = 9'h010,
		C_RECV = 9'h020, C_DONE = 9'h040, C_REP = 9'h080,
		C_RST = 9'h100;

	// ==========================================================
	// Declarations
	reg  [4:0]  ctrl_q;        // Control register
	reg         restart_q;     // Restart write pulse
	reg  [`LTG_RESTART_DLY-1:0] rs_dly_q; // Restart delay line
	reg  [9:0]  gst_q;         // Generator state
	reg         g_from1_q;     // Hold came from second state
	reg         init_done_q;   // Generator init complete
	reg         gen_busy_q;    // Generator busy
	reg         tx_done_q;     // Generator done flag
	reg         gen_arm_q;     // Generator may start a run
	reg  [15:0] tx_pkt_q;      // Packets sent
	reg  [7:0]  tx_beat_q;     // Beat within packet
	reg  [8:0]  cst_q;         // Checker state
	reg         lock_seen_q;   // checker_lock_seen
	reg         rx_busy_q;     // Checker busy
	reg         rx_done_q;     // Checker done flag
	reg         chk_arm_q;     // Checker may start a run
	reg  [15:0] rx_pkt_q;      // Packets received
	reg  [7:0]  rx_beat_q;     // Beat within received packet
	reg  [8:0]  err_q;         // Sticky mismatch flags
	reg         rx_err_q;      // Sticky summary error
	wire [3:0]  seg_dbad;      // Data mismatch per segment
	wire [3:0]  seg_cbad;      // Channel mismatch per segment
	wire        mty_bad;       // Empty count mismatch
	wire [1:0]  mode;          // Operating mode
	wire        gen_on;        // Generator enabled
	wire        chk_on;        // Checker enabled
	wire        gen_aligned;   // Alignment seen by generator
	wire        delayed_restart_request;
	wire        wr;            // APB write strobe
	wire        rd;            // APB read strobe
	wire        hit;           // Address is mapped
	wire        last_beat;     // Generator at packet end
	wire        rx_last;       // Checker saw final end marker

	// ==========================================================
	// Pattern shared by both sides
	function [`LTG_SEG_W-1:0] pat;
		input [15:0] pkt;
		input [7:0]  beat;
		input [7:0]  seg;
		begin
			pat = {4{pkt, beat, seg}};
		end
	endfunction

	// ==========================================================
	// Mode decode
	assign mode = ctrl_q[`LTG_CTRL_MODE_HI:`LTG_CTRL_MODE_LO];
	assign ctl_loopback = (mode == `LTG_MODE_DUPLEX);
	assign gen_on = (mode != `LTG_MODE_RXONLY);
	assign chk_on = (mode != `LTG_MODE_TXONLY);
	assign ctl_flow_packet = ctrl_q[`LTG_CTRL_FLOW];
	// Transmit-only has no receiver, so software stands in for it
	assign gen_aligned = (mode == `LTG_MODE_TXONLY) ?
		ctrl_q[`LTG_CTRL_ALIGN] : stat_rx_aligned;
	assign delayed_restart_request = rs_dly_q[`LTG_RESTART_DLY-1];

	// ==========================================================
	// APB slave: zero wait states, error on unmapped address
	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;
	assign hit = (paddr == `LTG_OFF_CTRL) ||
		(paddr == `LTG_OFF_STATUS) ||
		(paddr == `LTG_OFF_ERRORS) || (paddr == `LTG_OFF_COUNT);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

	// Control register and restart pulse
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `LTG_CTRL_RST;
			restart_q <= 1'b0;
		end else begin
			restart_q <= 1'b0;
			if (wr && paddr == `LTG_OFF_CTRL) begin
				ctrl_q <= {1'b0, pwdata[3:0]};
				restart_q <= pwdata[`LTG_CTRL_RESTART];
			end
		end
	end

	// Read data registered during setup, valid in access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd && !penable) begin
			case (paddr)
			`LTG_OFF_CTRL: prdata <= {28'h0000000, ctrl_q[3:0]};
			`LTG_OFF_STATUS: prdata <= {24'h000000,
				ctl_tx_enable, rx_err_q, lock_seen_q, mon_failed,
				mon_done, rx_busy_q, tx_done_q, gen_busy_q};
			`LTG_OFF_ERRORS: prdata <= {23'h000000, err_q};
			`LTG_OFF_COUNT: prdata <= {rx_pkt_q, tx_pkt_q};
			default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Restart request delay line
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rs_dly_q <= {`LTG_RESTART_DLY{1'b0}};
		end else begin
			rs_dly_q <= {rs_dly_q[`LTG_RESTART_DLY-2:0], restart_q};
		end
	end

	// ==========================================================
	// Generator
	assign last_beat = (tx_beat_q == `LTG_PKT_BEATS - 8'h01);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gst_q <= G_IDLE;
			g_from1_q <= 1'b0;
			init_done_q <= 1'b0;
			gen_busy_q <= 1'b0;
			tx_done_q <= 1'b0;
			gen_arm_q <= 1'b1;
			tx_pkt_q <= 16'h0000;
			tx_beat_q <= 8'h00;
			ctl_tx_enable <= 1'b0;
			ctl_tx_mubits <= `LTG_MUBITS;
			ctl_lanestat <= `LTG_LANESTAT;
			ctl_intfstat <= 1'b1;
			tx_data <= 512'h0;
			tx_ena <= 4'h0;
			tx_sop <= 4'h0;
			tx_eop <= 4'h0;
			tx_mty <= 16'h0000;
			tx_chan <= 44'h0;
		end else begin
			// Strobes last one beat unless re-driven
			tx_ena <= 4'h0;
			tx_sop <= 4'h0;
			tx_eop <= 4'h0;
			// Rearm on the delayed request so the checker is listening
			if (delayed_restart_request)
				gen_arm_q <= 1'b1;
			case (gst_q)
			G_IDLE: begin
				if (reset_done && gen_on && gen_arm_q)
					gst_q <= G_LOCK;
			end
			G_LOCK: begin
				ctl_tx_enable <= 1'b0;
				ctl_tx_mubits <= `LTG_MUBITS;
				ctl_lanestat <= `LTG_LANESTAT;
				ctl_intfstat <= 1'b1;
				init_done_q <= 1'b0;
				tx_done_q <= 1'b0;
				gst_q <= G_WAL;
			end
			G_WAL: begin
				if (gen_aligned)
					gst_q <= G_EN;
			end
			G_EN: begin
				ctl_tx_enable <= 1'b1;
				gst_q <= G_INIT;
			end
			G_INIT: begin
				tx_pkt_q <= 16'h0000;
				tx_beat_q <= 8'h00;
				gen_busy_q <= 1'b1;
				init_done_q <= 1'b1;
				if (init_done_q && tx_rdyout)
					gst_q <= G_TX0;
			end
			G_TX0: begin
				if (tx_pkt_q == `LTG_PKT_COUNT) begin
					gst_q <= G_DONE;
				end else if (!tx_rdyout) begin
					g_from1_q <= 1'b0;
					gst_q <= G_HOLD;
				end else begin
					// First beat with start marker
					tx_data <= {pat(tx_pkt_q, 8'h00, 8'h03),
						pat(tx_pkt_q, 8'h00, 8'h02),
						pat(tx_pkt_q, 8'h00, 8'h01),
						pat(tx_pkt_q, 8'h00, 8'h00)};
					tx_chan <= {4{tx_pkt_q[`LTG_CHAN_W-1:0]}};
					tx_ena <= 4'hf;
					tx_sop <= 4'h1;
					tx_mty <= 16'h0000;
					tx_beat_q <= 8'h01;
					gst_q <= G_TX1;
				end
			end
			G_TX1: begin
				if (!tx_rdyout) begin
					g_from1_q <= 1'b1;
					gst_q <= G_HOLD;
				end else begin
					tx_data <= {pat(tx_pkt_q, tx_beat_q, 8'h03),
						pat(tx_pkt_q, tx_beat_q, 8'h02),
						pat(tx_pkt_q, tx_beat_q, 8'h01),
						pat(tx_pkt_q, tx_beat_q, 8'h00)};
					tx_ena <= 4'hf;
					tx_beat_q <= tx_beat_q + 8'h01;
					if (last_beat) begin
						// Close the packet, then start the next
						tx_eop <= 4'h8;
						tx_mty <= {`LTG_PKT_MTY, 12'h000};
						tx_pkt_q <= tx_pkt_q + 16'h0001;
						tx_beat_q <= 8'h00;
						gst_q <= G_TX0;
					end
				end
			end
			G_HOLD: begin
				if (tx_rdyout)
					gst_q <= g_from1_q ? G_TX1 : G_TX0;
			end
			G_DONE: begin
				tx_done_q <= 1'b1;
				// A restart in the same cycle wins over disarming
				if (!delayed_restart_request)
					gen_arm_q <= 1'b0;
				gst_q <= G_RST;
			end
			G_RST: begin
				gen_busy_q <= 1'b0;
				gst_q <= G_IDLE;
			end
			default: gst_q <= G_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Checker comparators
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
			localparam integer SEG_N = gi; // Segment number
			ltg_seg_cmp u_cmp (
				.ena      (rx_ena[gi] && cst_q == C_RECV),
				.data     (rx_data[gi*128 +: 128]),
				.chan     (rx_chan[gi*11 +: 11]),
				.exp_data (pat(rx_pkt_q, rx_beat_q, SEG_N[7:0])),
				.exp_chan (rx_pkt_q[`LTG_CHAN_W-1:0]),
				.data_bad (seg_dbad[gi]),
				.chan_bad (seg_cbad[gi])
			);
		end
	endgenerate

	// Empty count checked on the closing segment
	assign mty_bad = (cst_q == C_RECV) && rx_ena[3] && rx_eop[3] &&
		(rx_mty[15:12] != `LTG_PKT_MTY);
	assign rx_last = rx_ena[3] && rx_eop[3] &&
		(rx_pkt_q == `LTG_PKT_COUNT - 16'h0001);

	// ==========================================================
	// Checker state machine
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cst_q <= C_IDLE;
			lock_seen_q <= 1'b0;
			rx_busy_q <= 1'b0;
			rx_done_q <= 1'b0;
			chk_arm_q <= 1'b1;
			rx_pkt_q <= 16'h0000;
			rx_beat_q <= 8'h00;
			err_q <= 9'h000;
			rx_err_q <= 1'b0;
			ctl_rx_enable <= 1'b0;
			mon_done <= 1'b0;
			mon_failed <= 1'b0;
		end else begin
			// Sticky flags, cleared only by reset
			err_q <= err_q | {mty_bad, seg_cbad, seg_dbad};
			if (|{mty_bad, seg_cbad, seg_dbad})
				rx_err_q <= 1'b1;
			case (cst_q)
			C_IDLE: begin
				if (reset_done && chk_on && chk_arm_q)
					cst_q <= C_LOCK;
			end
			C_LOCK: begin
				lock_seen_q <= 1'b1;
				rx_busy_q <= 1'b1;
				mon_done <= 1'b0;
				mon_failed <= 1'b0;
				cst_q <= C_WAL;
			end
			C_WAL: begin
				if (stat_rx_aligned)
					cst_q <= C_EN;
			end
			C_EN: begin
				ctl_rx_enable <= 1'b1;
				cst_q <= C_INIT;
			end
			C_INIT: begin
				rx_pkt_q <= 16'h0000;
				rx_beat_q <= 8'h00;
				rx_done_q <= 1'b0;
				cst_q <= C_RECV;
			end
			C_RECV: begin
				if (|rx_ena) begin
					rx_beat_q <= rx_beat_q + 8'h01;
					if (rx_eop[3]) begin
						rx_beat_q <= 8'h00;
						rx_pkt_q <= rx_pkt_q + 16'h0001;
					end
					if (rx_last)
						cst_q <= C_DONE;
				end
			end
			C_DONE: begin
				rx_done_q <= 1'b1;
				cst_q <= C_REP;
			end
			C_REP: begin
				mon_done <= 1'b1;
				mon_failed <= rx_err_q;
				chk_arm_q <= 1'b0;
				cst_q <= C_RST;
			end
			C_RST: begin
				ctl_rx_enable <= 1'b0;
				rx_busy_q <= 1'b0;
				rx_beat_q <= 8'h00;
				if (delayed_restart_request) begin
					chk_arm_q <= 1'b1;
					cst_q <= C_IDLE;
				end
			end
			default: cst_q <= C_IDLE;
			endcase
		end
	end
endmodule // ltg_traffic

`default_nettype wire

// file: include/ltg_regs.vh
/*
 * Constants for the lane traffic generator and checker: register offsets,
 * field positions, reset values, packet shape and timing counts.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`ifndef LTG_REGS_VH
`define LTG_REGS_VH

// ==========================================================
// Register byte offsets
`define LTG_OFF_CTRL      12'h000
`define LTG_OFF_STATUS    12'h004
`define LTG_OFF_ERRORS    12'h008
`define LTG_OFF_COUNT     12'h00c

// ==========================================================
// Control fields
`define LTG_CTRL_MODE_LO  0
`define LTG_CTRL_MODE_HI  1
`define LTG_CTRL_FLOW     2
`define LTG_CTRL_ALIGN    3
`define LTG_CTRL_RESTART  4
`define LTG_CTRL_RST      5'h04

// Operating modes
`define LTG_MODE_DUPLEX   2'h0
`define LTG_MODE_TXONLY   2'h1
`define LTG_MODE_RXONLY   2'h2

// ==========================================================
// Status fields
`define LTG_ST_GEN_BUSY   0
`define LTG_ST_TX_DONE    1
`define LTG_ST_RX_BUSY    2
`define LTG_ST_RX_DONE    3
`define LTG_ST_RX_FAIL    4
`define LTG_ST_LOCK       5
`define LTG_ST_RX_ERR     6
`define LTG_ST_TX_EN      7

// ==========================================================
// Packet shape shared by both sides
`define LTG_PKT_COUNT     16'h0010
`define LTG_PKT_BEATS     8'h04
`define LTG_PKT_MTY       4'h0
`define LTG_SEG_W         128
`define LTG_CHAN_W        11

// ==========================================================
// Link-lock values and restart delay
`define LTG_LANESTAT      12'hfff
`define LTG_MUBITS        8'h00
`define LTG_RESTART_DLY   3

`endif

// file: hdl/ltg_seg_cmp.v
/*
 * One segment comparator: flags data and channel mismatch of a
 * received segment against its expected value.
 * Assumes inputs are valid in the cycle that enable is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ltg_regs.vh"

module ltg_seg_cmp (
	input  wire                    ena,      // Segment carries data
	input  wire [`LTG_SEG_W-1:0]   data,     // Received data
	input  wire [`LTG_CHAN_W-1:0]  chan,     // Received channel
	input  wire [`LTG_SEG_W-1:0]   exp_data, // Expected data
	input  wire [`LTG_CHAN_W-1:0]  exp_chan, // Expected channel
	output wire                    data_bad, // Data mismatch
	output wire                    chan_bad  // Channel mismatch
);
	// ==========================================================
	// Compare
	assign data_bad = ena && (data != exp_data);
	assign chan_bad = ena && (chan != exp_chan);
endmodule // ltg_seg_cmp

`default_nettype wire

// file: dv/ltg_traffic_props.sv
/* Port checker for ltg_traffic: APB answers, transmit framing, hold
   and checker report. Assumes one clock, pclk, and async presetn. */
`timescale 1ns/1ps
`default_nettype none

module ltg_chk (
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic [11:0]  paddr,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic         reset_done,
	input wire logic         tx_rdyout,
	input wire logic [511:0] tx_data,
	input wire logic [3:0]   tx_ena,
	input wire logic [3:0]   tx_sop,
	input wire logic [3:0]   tx_eop,
	input wire logic [15:0]  tx_mty,
	input wire logic [43:0]  tx_chan,
	input wire logic         ctl_tx_enable,
	input wire logic [7:0]   ctl_tx_mubits,
	input wire logic [11:0]  ctl_lanestat,
	input wire logic         ctl_intfstat,
	input wire logic         ctl_rx_enable,
	input wire logic         mon_done,
	input wire logic         mon_failed
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Packet steps
	sequence s_start; tx_sop[0] && tx_ena == 4'hf; endsequence
	sequence s_end; tx_eop[3] && tx_ena == 4'hf; endsequence
	// ==========================================================
	// Assertions
	AST_READY: assert property (psel && penable |-> pready)
		else $error("access without ready");
	AST_SLVERR: assert property (psel && penable |-> pslverr ==
		!(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
		else $error("wrong error answer");
	AST_IDLE: assert property (!reset_done |-> tx_ena == 4'h0)
		else $error("beat before reset done");
	AST_LOCKVAL: assert property (!ctl_tx_enable |-> ctl_lanestat ==
		12'hfff && ctl_intfstat && ctl_tx_mubits == 8'h00)
		else $error("lock values wrong");
	AST_GATE: assert property (tx_ena != 4'h0 |-> ctl_tx_enable)
		else $error("beat while disabled");
	AST_SOP: assert property (tx_sop != 4'h0 |-> s_start and
		tx_sop == 4'h1)
		else $error("bad start marker");
	AST_PKT: assert property (s_start |-> ##[0:60] s_end)
		else $error("packet never ends");
	AST_EOP: assert property (tx_eop != 4'h0 |-> s_end and
		tx_eop == 4'h8 && tx_mty[15:12] == 4'h0)
		else $error("bad end marker");
	AST_GAP: assert property (s_end |=> tx_ena == 4'h0 ||
		(tx_sop == 4'h1 && tx_ena == 4'hf))
		else $error("beat after end without start");
	AST_HOLD: assert property (!tx_rdyout [*2] |-> tx_ena == 4'h0)
		else $error("beat while not ready");
	AST_PAT: assert property (tx_ena != 4'h0 |-> tx_chan[10:0] ==
		tx_data[26:16] && tx_data[7:0] == 8'h00
		&& tx_data[135:128] == 8'h01)
		else $error("bad segment pattern");
	AST_FAIL: assert property (mon_failed |-> mon_done)
		else $error("failed without done");
	AST_RESTART: assert property ($rose(mon_done) |->
		##[0:2] !ctl_rx_enable)
		else $error("checker stays enabled");
endmodule // ltg_chk

bind ltg_traffic ltg_chk u_chk (.pclk, .presetn, .psel, .penable,
	.paddr, .pready, .pslverr, .reset_done, .tx_rdyout, .tx_data,
	.tx_ena, .tx_sop, .tx_eop, .tx_mty, .tx_chan, .ctl_tx_enable,
	.ctl_tx_mubits, .ctl_lanestat, .ctl_intfstat, .ctl_rx_enable,
	.mon_done, .mon_failed);

`default_nettype wire

// file: dv/ltg_core_model.sv
/* Behavioural model of the link core user side: reset done,
   alignment, ready and serial loopback. Assumes bench commands. */
`timescale 1ns/1ps
`default_nettype none

module ltg_core_model (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         core_up,  // Core reset may finish
	input  wire logic         align_en, // Receiver can align
	input  wire logic         stall,    // Withhold ready
	input  wire logic         corrupt,  // Damage looped beats
	input  wire logic         loop_on,  // Loopback requested
	input  wire logic [511:0] tx_data,
	input  wire logic [3:0]   tx_ena,
	input  wire logic [3:0]   tx_sop,
	input  wire logic [3:0]   tx_eop,
	input  wire logic [15:0]  tx_mty,
	input  wire logic [43:0]  tx_chan,
	output logic              reset_done,
	output logic              stat_rx_aligned,
	output logic              tx_rdyout,
	output logic [511:0]      rx_data,
	output logic [3:0]        rx_ena,
	output logic [3:0]        rx_sop,
	output logic [3:0]        rx_eop,
	output logic [15:0]       rx_mty,
	output logic [43:0]       rx_chan
);
	logic [3:0] up_q; // Cycles since reset done
	assign tx_rdyout = !stall;
	// Alignment follows reset done; loop beats back one cycle later
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_done <= 1'b0;
			stat_rx_aligned <= 1'b0;
			up_q <= 4'h0;
			rx_ena <= 4'h0;
			rx_sop <= 4'h0;
			rx_eop <= 4'h0;
			rx_data <= '0;
			rx_mty <= 16'h0;
			rx_chan <= 44'h0;
		end else begin
			reset_done <= core_up;
			up_q <= !reset_done ? 4'h0 : (up_q == 4'hf ? up_q : up_q + 4'h1);
			stat_rx_aligned <= align_en && up_q == 4'hf;
			if (loop_on && tx_ena != 4'h0) begin
				rx_data <= tx_data ^ {511'h0, corrupt};
				rx_chan <= tx_chan ^ {32'h0, corrupt, 11'h0};
				rx_ena <= tx_ena;
				rx_sop <= tx_sop;
				rx_eop <= tx_eop;
				rx_mty <= tx_mty;
			end else begin
				// Idle bus shows changing junk
				rx_ena <= 4'h0;
				rx_sop <= 4'h0;
				rx_eop <= 4'h0;
				rx_data <= ~rx_data;
				rx_mty <= ~rx_mty;
				rx_chan <= ~rx_chan;
			end
		end
	end
endmodule // ltg_core_model

`default_nettype wire

// file: dv/ltg_traffic_test.sv
/* Testbench for ltg_traffic: APB tasks, loopback runs, fault run,
   transmit-only override. Assumes ltg_core_model as the core. */
`timescale 1ns/1ps
`default_nettype none
`include "ltg_regs.vh"

module ltg_traffic_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic reset_done, stat_rx_aligned, tx_rdyout;
	logic [511:0] tx_data, rx_data;
	logic [3:0] tx_ena, tx_sop, tx_eop, rx_ena, rx_sop, rx_eop;
	logic [15:0] tx_mty, rx_mty;
	logic [43:0] tx_chan, rx_chan;
	logic ctl_tx_enable, ctl_intfstat, ctl_rx_enable, ctl_loopback;
	logic ctl_flow_packet, mon_done, mon_failed;
	logic [7:0] ctl_tx_mubits;
	logic [11:0] ctl_lanestat;
	logic core_up, align_en, stall, corrupt;
	int num_errors, num_checks, i;

	ltg_traffic u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .reset_done, .stat_rx_aligned,
		.tx_rdyout, .tx_data, .tx_ena, .tx_sop, .tx_eop, .tx_mty, .tx_chan,
		.rx_data, .rx_ena, .rx_sop, .rx_eop, .rx_mty, .rx_chan,
		.ctl_tx_enable, .ctl_tx_mubits, .ctl_lanestat, .ctl_intfstat,
		.ctl_rx_enable, .ctl_loopback, .ctl_flow_packet, .mon_done,
		.mon_failed);
	ltg_core_model u_core (.pclk, .presetn, .core_up, .align_en, .stall,
		.corrupt, .loop_on(ctl_loopback), .tx_data, .tx_ena, .tx_sop,
		.tx_eop, .tx_mty, .tx_chan, .reset_done, .stat_rx_aligned,
		.tx_rdyout, .rx_data, .rx_ena, .rx_sop, .rx_eop, .rx_mty, .rx_chan);

	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic wait_done(input logic v);
		for (i = 0; i < 3000 && mon_done !== v; i++) @(posedge pclk);
		check(32'(mon_done), 32'(v));
	endtask
	// Restart both sides and wait for a full new report
	task automatic run(input logic c);
		corrupt <= c;
		apb(1'b1, `LTG_OFF_CTRL, 32'h14);
		wait_done(1'b0);
		wait_done(1'b1);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		finish_test;
	end

	// ==========================================================
	// Tests
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{core_up, stall, corrupt} = 3'h0;
		align_en = 1'b1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, unmapped access, mode outputs
		check(32'(ctl_lanestat), 32'hfff);
		rdchk(`LTG_OFF_CTRL, 32'h4);
		rdchk(`LTG_OFF_COUNT, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		check(rd, 32'h0);
		check(32'(err), 32'h1);
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, `LTG_OFF_CTRL, 32'(m));
			@(posedge pclk);
			check(32'(ctl_loopback), 32'(m == 0));
			check(32'(ctl_flow_packet), 32'h0);
		end
		$display("test reset and modes done");
		// Duplex loopback run with a ready stall mid-run
		apb(1'b1, `LTG_OFF_CTRL, 32'h4);
		@(posedge pclk);
		check(32'(ctl_flow_packet), 32'h1);
		core_up <= 1'b1;
		for (i = 0; i < 500 && tx_sop[0] !== 1'b1; i++) @(posedge pclk);
		stall <= 1'b1;
		repeat (3) @(posedge pclk);
		stall <= 1'b0;
		wait_done(1'b1);
		check(32'(mon_failed), 32'h0);
		rdchk(`LTG_OFF_COUNT, {`LTG_PKT_COUNT, `LTG_PKT_COUNT});
		apb(1'b0, `LTG_OFF_STATUS, 32'h0);
		check(rd, 32'haa);
		rdchk(`LTG_OFF_ERRORS, 32'h0);
		$display("test duplex run done");
		// Damaged run, then a clean run: error must stay
		run(1'b1);
		check(32'(mon_failed), 32'h1);
		rdchk(`LTG_OFF_ERRORS, 32'h21);
		run(1'b0);
		check(32'(mon_failed), 32'h1);
		$display("test error runs done");
		// Transmit-only waits for the alignment override
		align_en <= 1'b0;
		apb(1'b1, `LTG_OFF_CTRL, 32'h15);
		repeat (30) @(posedge pclk);
		check(32'(ctl_tx_enable), 32'h0);
		check(32'(ctl_loopback), 32'h0);
		apb(1'b1, `LTG_OFF_CTRL, 32'h0d);
		for (i = 0; i < 100 && ctl_tx_enable !== 1'b1; i++) @(posedge pclk);
		check(32'(ctl_tx_enable), 32'h1);
		$display("test transmit-only done");
		finish_test;
	end
endmodule // ltg_traffic_test

`default_nettype wire
